// file: irc_regs.svh
/*
 * Register offsets, field positions, reset values and codes for the IR
 * carrier and modulator timing block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH

// Word indices; byte address is four times the index.
`define IRC_IDX_CTRL        4'h4
`define IRC_IDX_CARRIER     4'h5
`define IRC_IDX_MODTIME     4'h6
`define IRC_IDX_TIMER       4'h7
// Control register field positions.
`define IRC_CTRL_EN_BIT     0
`define IRC_CTRL_RXMODE_BIT 1
`define IRC_CTRL_BCNT_BIT   3
`define IRC_CTRL_EDGE_LO    8
`define IRC_CTRL_DIV_LO     10
`define IRC_CTRL_WMASK      16'h1F0B
// Reset values and the burst count load value.
`define IRC_CARRIER_RST     16'h0000
`define IRC_MODTIME_RST     16'h0000
`define IRC_CTRL_RST        16'h0000
`define IRC_BCNT_LOAD       16'h0001
// Receive edge select codes.
`define IRC_EDGE_NONE       2'h0
`define IRC_EDGE_FALL       2'h1
`define IRC_EDGE_RISE       2'h2
`define IRC_EDGE_BOTH       2'h3

`endif

// file: irc_pkg.sv
/*
 * Types shared by the IR carrier block files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package irc_pkg;
  // Carrier phase states, one-hot.
  typedef enum logic [1:0] {
    IRC_LOW  = 2'h1,
    IRC_HIGH = 2'h2
  } irc_phase_e;
endpackage : irc_pkg

// file: irc_tick_if.sv
/*
 * Carrier between the prescaler and the main module.
 * Assumes a single clock domain.
 */
interface irc_tick_if;
  logic [2:0] div_sel;  // Divide selection code.
  logic       tick;     // One-cycle IR input clock pulse.
  modport src (input div_sel, output tick);
  modport dst (output div_sel, input tick);
endinterface : irc_tick_if

// file: irc_prescaler.sv
/*
 * Prescaler making the IR input clock enable from the system clock.
 * Assumes rst_i asynchronous active high, single clock.
 */
`include "irc_regs.svh"
module irc_prescaler (
  input  wire logic sys_clk_i,  // System clock.
  input  wire logic rst_i,      // Asynchronous reset.
  irc_tick_if.src   tk          // Divide code in, tick out.
);
  // ************************************************************
  // Divider counter
  // ************************************************************
  logic [6:0] cnt_reg;   // Free running count.
  logic [6:0] cnt_next;  // Next count.
  logic       tick_reg;  // Registered tick.
  logic       tick_next; // Next tick.
  logic [6:0] lim;       // Terminal count, two to the code less one.

  // A tick every 2**code clocks; code 000 ticks every clock.
  always_comb begin
    lim       = 7'((8'h01 << tk.div_sel) - 8'h01);
    tick_next = (cnt_reg >= lim);
    cnt_next  = tick_next ? 7'h00 : 7'(cnt_reg + 7'h01);
  end

  // Register the counter.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tk.tick = tick_reg;
endmodule : irc_prescaler

// file: irc_carrier_mod.sv
/*
 * IR carrier and modulator timing block with a classic Wishbone slave.
 * Assumes a 25 MHz sys_clk_i, rst_i asynchronous active high, and
 * a receive pin already synchronous to the clock.
 */
`include "irc_regs.svh"
module irc_carrier_mod (
  input  wire logic        sys_clk_i,  // System clock, 25 MHz.
  input  wire logic        rst_i,      // Asynchronous reset.
  input  wire logic        cyc_i,      // Wishbone cycle.
  input  wire logic        stb_i,      // Wishbone strobe.
  input  wire logic        we_i,       // Wishbone write enable.
  input  wire logic [3:0]  adr_i,      // Word address.
  input  wire logic [3:0]  sel_i,      // Byte selects.
  input  wire logic [31:0] dat_i,      // Write data.
  output logic      [31:0] dat_o,      // Read data.
  output logic             ack_o,      // Wishbone acknowledge.
  input  wire logic        ir_rx_i,    // IR receive input.
  output logic             carrier_o,  // Raw carrier.
  output logic             ir_data_output_o // Modulated data output.
);
  // ************************************************************
  // Declarations
  // ************************************************************
  irc_tick_if tk ();
  logic [15:0] ir_control_reg, ctrl_next;         // Control register.
  logic [15:0] carrier_timing_reg, carr_next;     // Carrier timing.
  logic [15:0] modulator_time_reg, mt_next;       // Modulator time.
  logic [15:0] ir_timer_value_reg, tv_next;       // IR timer.
  logic [7:0]  ph_cnt_reg, ph_cnt_next;           // Phase count.
  irc_pkg::irc_phase_e phase_reg, phase_next;     // Carrier phase.
  logic        active_reg, active_next;           // Data window open.
  logic        rx_d_reg;                          // Prior receive level.
  logic        ack_next;                          // Next ack.
  logic [31:0] dat_next;                          // Next read data.
  logic        car_next, dout_next;               // Next outputs.
  logic        wr;                                // Write lands this edge.
  logic        edge_hit;                          // Qualified rx edge.
  logic        rx_mode;                           // One in receive mode.
  logic        en;                                // Timer enable.
  logic        bcnt_rise;                         // Burst enable 0 to 1.
  logic [1:0]  edge_sel;                          // Receive edge select.
  logic [15:0] ctrl_rd;                           // Control read view.

  // ************************************************************
  // Prescaler
  // ************************************************************
  // The prescaler owns its counter; this module only supplies the code.
  // A code change takes effect at once against the running count, so the first period
  // after a change may differ from the new ratio.
  assign tk.div_sel = ir_control_reg[`IRC_CTRL_DIV_LO +: 3];
  irc_prescaler u_pre (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tk        (tk.src)
  );

  // ************************************************************
  // Bus and register update
  // ************************************************************
  // Field views of the control register, decoded once for both processes.
  assign en       = ir_control_reg[`IRC_CTRL_EN_BIT];
  assign rx_mode  = ir_control_reg[`IRC_CTRL_RXMODE_BIT];
  assign edge_sel = ir_control_reg[`IRC_CTRL_EDGE_LO +: 2];
  // Reserved upper bits are forced to zero on read, whatever is stored.
  assign ctrl_rd  = {3'h0, ir_control_reg[12:0]};

  // Combine bus writes with hardware updates; writes happen on ack.
  always_comb begin
    // A write is applied on the edge at which the master sees ack, so a
    // master that drops the cycle before ack leaves the register untouched.
    wr        = cyc_i && stb_i && we_i && ack_o;
    // Ack follows the request by one cycle; a held strobe is answered
    // every other cycle because ack itself blocks the next answer.
    ack_next  = cyc_i && stb_i && !ack_o;
    ctrl_next = ir_control_reg;
    carr_next = carrier_timing_reg;
    mt_next   = modulator_time_reg;
    dat_next  = 32'h0000_0000;
    // Classify the receive pin change against its value one clock ago.
    unique case (ir_rx_i && !rx_d_reg ? `IRC_EDGE_RISE :
                 !ir_rx_i && rx_d_reg ? `IRC_EDGE_FALL : `IRC_EDGE_NONE)
      `IRC_EDGE_RISE: edge_hit = edge_sel[1];
      `IRC_EDGE_FALL: edge_hit = edge_sel[0];
      default:        edge_hit = 1'b0;
    endcase
    edge_hit = edge_hit && en && rx_mode;
    // Hardware updates first so that a bus write in the same cycle wins.
    if (edge_hit) begin
      if (ir_control_reg[`IRC_CTRL_BCNT_BIT]) begin
        mt_next = 16'(modulator_time_reg + 16'h0001);
      end else begin
        mt_next = ir_timer_value_reg;
      end
    end
    // Only a full low half-word write is taken; partial selects are acked
    // and dropped, since the registers have no byte lanes of their own.
    if (wr && sel_i[0] && sel_i[1]) begin
      unique case (adr_i)
        `IRC_IDX_CTRL:    ctrl_next = dat_i[15:0] & `IRC_CTRL_WMASK;
        `IRC_IDX_CARRIER: carr_next = dat_i[15:0];
        `IRC_IDX_MODTIME: mt_next   = dat_i[15:0];
        default: ;
      endcase
    end
    // Rising burst enable loads one; only meaningful in receive mode.
    // The load is checked after the write so that it wins over an edge.
    bcnt_rise = ctrl_next[`IRC_CTRL_BCNT_BIT] &&
                !ir_control_reg[`IRC_CTRL_BCNT_BIT];
    if (bcnt_rise && ctrl_next[`IRC_CTRL_RXMODE_BIT]) begin
      mt_next = `IRC_BCNT_LOAD;
    end
    // Read data is registered with ack so both stand for the same cycle.
    if (ack_next && !we_i) begin
      unique case (adr_i)
        `IRC_IDX_CTRL:    dat_next = {16'h0000, ctrl_rd};
        `IRC_IDX_CARRIER: dat_next = {16'h0000, carrier_timing_reg};
        `IRC_IDX_MODTIME: dat_next = {16'h0000, modulator_time_reg};
        `IRC_IDX_TIMER:   dat_next = {16'h0000, ir_timer_value_reg};
        default:          dat_next = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Carrier and modulator timing
  // ************************************************************
  // Timer counts IR clocks; in transmit it closes the data window
  // after modulator time ticks and then reopens it (reload).
  always_comb begin
    phase_next  = phase_reg;
    ph_cnt_next = ph_cnt_reg;
    tv_next     = ir_timer_value_reg;
    active_next = active_reg;
    if (!en) begin
      // Disabled: hold the carrier low and the window shut.
      phase_next  = irc_pkg::IRC_LOW;
      ph_cnt_next = 8'h00;
      tv_next     = 16'h0000;
      active_next = 1'b0;
    end else if (tk.tick) begin
      // All carrier and window state moves only on IR clock ticks.
      unique case (phase_reg)
        irc_pkg::IRC_LOW: begin
          // Leave low after low byte plus one ticks.
          if (ph_cnt_reg >= carrier_timing_reg[7:0]) begin
            phase_next  = irc_pkg::IRC_HIGH;
            ph_cnt_next = 8'h00;
          end else begin
            ph_cnt_next = 8'(ph_cnt_reg + 8'h01);
          end
        end
        irc_pkg::IRC_HIGH: begin
          // Leave high after high byte plus one ticks.
          if (ph_cnt_reg >= carrier_timing_reg[15:8]) begin
            phase_next  = irc_pkg::IRC_LOW;
            ph_cnt_next = 8'h00;
          end else begin
            ph_cnt_next = 8'(ph_cnt_reg + 8'h01);
          end
        end
      endcase
      // In transmit the timer runs against the modulator time; in receive
      // it free-runs so that a capture reads IR clocks since the last edge.
      if (!rx_mode && tv_next >= modulator_time_reg) begin
        tv_next     = 16'h0000;
        active_next = 1'b0;
      end else begin
        tv_next     = 16'(ir_timer_value_reg + 16'h0001);
        active_next = !rx_mode;
      end
    end
    // A capture restarts the timer so the next capture measures one gap.
    if (edge_hit && !ir_control_reg[`IRC_CTRL_BCNT_BIT]) begin
      tv_next = 16'h0000;
    end
    // Outputs are built from next state so the flops match the phase.
    car_next  = (phase_next == irc_pkg::IRC_HIGH);
    dout_next = active_next && car_next;
  end

  // Register all state; reset clears every register except phase_reg, which loads IRC_LOW.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_control_reg     <= `IRC_CTRL_RST;
      carrier_timing_reg <= `IRC_CARRIER_RST;
      modulator_time_reg <= `IRC_MODTIME_RST;
      ir_timer_value_reg <= 16'h0000;
      ph_cnt_reg         <= 8'h00;
      phase_reg          <= irc_pkg::IRC_LOW;
      active_reg         <= 1'b0;
      rx_d_reg           <= 1'b0;
      ack_o              <= 1'b0;
      dat_o              <= 32'h0000_0000;
      carrier_o          <= 1'b0;
      ir_data_output_o   <= 1'b0;
    end else begin
      ir_control_reg     <= ctrl_next;
      carrier_timing_reg <= carr_next;
      modulator_time_reg <= mt_next;
      ir_timer_value_reg <= tv_next;
      ph_cnt_reg         <= ph_cnt_next;
      phase_reg          <= phase_next;
      active_reg         <= active_next;
      // The pin is taken as synchronous already; no extra stage here.
      rx_d_reg           <= ir_rx_i;
      ack_o              <= ack_next;
      dat_o              <= dat_next;
      carrier_o          <= car_next;
      ir_data_output_o   <= dout_next;
    end
  end
endmodule : irc_carrier_mod

// file: irc_carrier_mod_props.sv
/* Port checker for irc_carrier_mod.
   Assumes one clock; the bind at the foot attaches it. */
module irc_props (
  input wire logic        sys_clk_i,       // Clock.
  input wire logic        rst_i,           // Reset.
  input wire logic        cyc_i,           // Cycle.
  input wire logic        stb_i,           // Strobe.
  input wire logic        we_i,            // Write.
  input wire logic [3:0]  adr_i,           // Index.
  input wire logic [3:0]  sel_i,           // Selects.
  input wire logic [31:0] dat_i,           // Write data.
  input wire logic [31:0] dat_o,           // Read data.
  input wire logic        ack_o,           // Acknowledge.
  input wire logic        ir_rx_i,         // Receive pin.
  input wire logic        carrier_o,       // Carrier.
  input wire logic        ir_data_output_o // Data out.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Shadows
  // ****
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] car_reg;  // Last carrier write.
  logic [15:0] ctl_reg;  // Last control write.
  wire logic   wr = ack_o && we_i && sel_i[1:0] == 2'h3; // Write lands.
  wire logic   rd = ack_o && !we_i;                      // Read answer.
  // Writes land on the ack edge, so shadows update there too.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      car_reg <= 16'h0000;
      ctl_reg <= 16'h0000;
    end else if (wr && adr_i == 4'h5) begin
      car_reg <= dat_i[15:0];
    end else if (wr && adr_i == 4'h4) begin
      ctl_reg <= dat_i[15:0];
    end
  end
  ack_resp_a:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  ack_pulse_a:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  rsvd_zero_a:
    assert property (rd && adr_i == 4'h4 |-> dat_o[15:13] == 3'h0)
    else $error("reserved bits set");
  ctl_read_a:
    assert property (rd && adr_i == 4'h4 |-> dat_o[15:0] == (ctl_reg & 16'h1F0B))
    else $error("control readback");
  car_read_a:
    assert property (rd && adr_i == 4'h5 |-> dat_o[15:0] == car_reg)
    else $error("carrier readback");
  upper_zero_a:
    assert property (rd |-> dat_o[31:16] == 16'h0000) else $error("upper bits");
  unmapped_a:
    assert property (rd && (adr_i[3] || adr_i[3:2] == 2'h0) |-> dat_o == 0)
    else $error("unmapped read");
  // A divided clock cannot toggle the carrier on two adjacent edges.
  toggle_rate_a:
    assert property (ctl_reg[12:10] != 3'h0 && $changed(carrier_o) && !ack_o
      && !$past(ack_o) && !$past(ack_o, 2) |=> $stable(carrier_o))
    else $error("carrier too fast");
endmodule : irc_props
bind irc_carrier_mod irc_props i_irc_props (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ir_rx_i(ir_rx_i), .carrier_o(carrier_o),
  .ir_data_output_o(ir_data_output_o));

// file: irc_ir_partner.sv
/* IR receiver front end feeding the block's receive pin.
   Assumes the pin is sampled on the system clock. */
module irc_ir_partner (
  input  wire logic clk_i, // System clock.
  output logic      rx_o   // Receive pin.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle low between marks, as a receiver with no signal.
  initial rx_o = 1'b0;
  // Each mark is 8 cycles high then 9 low; rises are 17 apart.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      rx_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      rx_o <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask : pulses
endmodule : irc_ir_partner

// file: irc_carrier_mod_test.sv
/* Self-checking bench for irc_carrier_mod.
   Assumes the partner model and the bound checker. */
module irc_carrier_mod_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0; // Index and selects.
  logic [31:0] wd = 32'h0, rd, q;      // Bus data, last read.
  logic        ack, car, txd, rx;      // Outputs and pin.
  int          miscompares = 0;        // Mismatches.
  int          n_tests = 0;            // Comparisons.
  int          h, l;                   // Measured counts.
  always #20 clk = ~clk;
  irc_carrier_mod i_irc_carrier_mod (.sys_clk_i(clk), .rst_i(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wd), .dat_o(rd), .ack_o(ack), .ir_rx_i(rx),
    .carrier_o(car), .ir_data_output_o(txd));
  irc_ir_partner i_irc_ir_partner (.clk_i(clk), .rx_o(rx));
  // ****
  // Tasks
  // ****
  // Classic cycle: hold until ack is seen at an edge.
  task automatic wb(input logic w, input logic [3:0] a, s,
                    input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic chk(input string n, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic rc(input logic [3:0] a, input logic [31:0] e, string n);
    wb(1'b0, a, 4'hF, 16'h0000);
    chk(n, q, e);
  endtask : rc
  // Lengths in cycles of one full high and the low after it.
  task automatic phases(output int hi, lo);
    hi = 0;
    lo = 0;
    @(posedge car);
    while (car === 1'b1) begin
      @(posedge clk);
      #1 hi++;
    end
    while (car === 1'b0) begin
      @(posedge clk);
      #1 lo++;
    end
  endtask : phases
  // Cycles with carrier high and with data output high, over 64.
  task automatic highs(output int nc, nd);
    nc = 0;
    nd = 0;
    repeat (64) begin
      @(posedge clk);
      #1 nc += (car === 1'b1);
      nd += (txd === 1'b1);
    end
  endtask : highs
  task automatic results;
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial begin
    #(40 * 30000);
    miscompares++;
    results();
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 4; a < 7; a++) rc(a[3:0], 32'h0, "reset");
    wb(1'b1, 4'h5, 4'hF, 16'hA55A);
    rc(4'h5, 32'hA55A, "carrier");
    wb(1'b1, 4'h5, 4'h0, 16'h1111);
    rc(4'h5, 32'hA55A, "unselected");
    wb(1'b1, 4'h4, 4'hF, 16'hFFFF);
    rc(4'h4, 32'h1F0B, "control");
    rc(4'h6, 32'h1, "burst load");
    rc(4'hF, 32'h0, "unmapped");
    wb(1'b1, 4'h5, 4'hF, 16'h0402);
    for (int d = 0; d < 8; d++) begin
      wb(1'b1, 4'h4, 4'hF, 16'h0001 | 16'(d << 10));
      phases(h, l);
      chk("high phase", h, 5 << d);
      chk("low phase", l, 3 << d);
    end
    wb(1'b1, 4'h4, 4'hF, 16'h0001);
    wb(1'b1, 4'h6, 4'hF, 16'h1234);
    wb(1'b1, 4'h4, 4'hF, 16'h0009);
    rc(4'h6, 32'h1234, "tx burst");
    wb(1'b1, 4'h5, 4'hF, 16'h0000);
    wb(1'b1, 4'h6, 4'hF, 16'hFFFF);
    highs(h, l);
    chk("open window", l, h);
    // A four-tick window against a two-tick carrier hits both phases.
    wb(1'b1, 4'h6, 4'hF, 16'h0004);
    highs(h, l);
    chk("short window", 32'(l < h), 1);
    for (int c = 1; c < 4; c++) begin
      wb(1'b1, 4'h4, 4'hF, 16'h0003 | 16'(c << 8));
      wb(1'b1, 4'h4, 4'hF, 16'h000B | 16'(c << 8));
      rc(4'h6, 32'h1, "burst start");
      i_irc_ir_partner.pulses(2);
      rc(4'h6, (c == 3) ? 32'h5 : 32'h3, "burst count");
    end
    wb(1'b1, 4'h4, 4'hF, 16'h0203);
    i_irc_ir_partner.pulses(2);
    wb(1'b0, 4'h6, 4'hF, 16'h0000);
    chk("capture", 32'(q >= 16 && q <= 18), 1);
    results();
  end
endmodule : irc_carrier_mod_test
